/* File: inc/cio_pkg.sv */
// Purpose: shared constants for the I/O and control instruction unit
// Assumes: APB register access, 32-bit data, one clock
// Notes: offsets are byte addresses of aligned words
package cio_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0C;
  localparam logic [7:0] OFS_GPR = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_CTL0 = 8'h18;
  localparam logic [7:0] OFS_CTL1 = 8'h1C;
  localparam logic [7:0] OFS_MODE = 8'h20;

  // ************************************************************
  // Command field layout (CMD register)
  // ************************************************************
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int ARG_LSB = 8;
  localparam int BYTE_BIT = 16;
  localparam int SEL_BIT = 17;

  // Status bits
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_S = 2;
  localparam int ST_PV = 3;
  localparam int ST_NVI = 4;
  localparam int ST_VI = 5;
  localparam int ST_BUSY = 8;
  localparam int ST_PRIV = 9;
  localparam int ST_HALT = 10;
  localparam int ST_MLINE = 11;

  // Reset values
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] IEN_RST = 2'h0;
  localparam logic SYS_RST = 1'b1;

  // Opcodes
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRD_DN = 5'h01, OP_BRD_UP = 5'h02, OP_BWR_DN = 5'h03,
    OP_BWR_UP = 5'h04, OP_SRD_STEP_DN = 5'h05, OP_SWR_STEP_UP = 5'h06,
    OP_SBWR_DN = 5'h07, OP_IRQ_UNMASK = 5'h08, OP_IRQ_MASK = 5'h09,
    OP_FLAG_TOGGLE = 5'h0A, OP_FLAG_HIGH = 5'h0B, OP_FLAG_CLEAR = 5'h0C,
    OP_CTL_STORE = 5'h0D, OP_CTL_LOAD = 5'h0E, OP_FB_STORE = 5'h0F,
    OP_FB_LOAD = 5'h10, OP_MLINE_TEST = 5'h11, OP_MLINE_ASSERT = 5'h12,
    OP_MLINE_RELEASE = 5'h13, OP_HALT = 5'h14, OP_LOAD_PS = 5'h15
  } cio_op_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_MEMRD = 4'b0010, ST_XFER = 4'b0100, ST_STEP = 4'b1000
  } cio_state_t;

endpackage

/* File: logic/cio_fifo.sv */
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes: depth must be a power of two
`timescale 1ns/10ps
module cio_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;

  // Refuse sizes that the wrapping pointers cannot serve
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_size
    $error("cio_fifo depth must be a power of two and width positive");
  end

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (do_wr) mem[wptr[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_wr) wptr <= wptr + 1'b1;
      if (do_rd) rptr <= rptr + 1'b1;
    end
  end
endmodule // cio_fifo

/* File: logic/cio_top.sv */
// Purpose: execution unit for port transfer and processor control operations
// Assumes: APB slave, peripheral port bus with request/ack, memory with request/ack
// Notes: incoming port data passes through a FIFO before memory write
`timescale 1ns/10ps
module cio_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Peripheral port bus
  output logic PORT_REQ,
  output logic PORT_WR,
  output logic PORT_SPECIAL,
  output logic PORT_BYTE,
  output logic [15:0] PORT_ADDR,
  output logic [15:0] PORT_WDATA,
  input wire logic PORT_ACK,
  input wire logic [15:0] PORT_RDATA,
  // Memory bus
  output logic MEM_REQ,
  output logic MEM_WR,
  output logic MEM_BYTE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // Multi-processor line and interrupt enables
  input wire logic MULTICPU_IN_LINE_N,
  output logic MULTICPU_OUT_LINE_N,
  output logic NONVECTORED_IRQ_EN,
  output logic VECTORED_IRQ_EN
);
  import cio_pkg::*;

  // ************************************************************
  // Architectural state
  // ************************************************************
  cio_state_t state;
  cio_op_t op;
  logic is_byte;
  logic [15:0] src;
  logic [15:0] dst;
  logic [15:0] cnt;
  logic [15:0] gpr;
  logic [15:0] ctl0;
  logic [15:0] ctl1;
  logic [3:0] flags;
  logic [1:0] ien;
  logic sys_mode;
  logic halted;
  logic mline;
  logic priv_err;
  logic [15:0] hold;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire apb_rd_hit = (PADDR == OFS_CMD) || (PADDR == OFS_SRC) || (PADDR == OFS_DST) ||
    (PADDR == OFS_CNT) || (PADDR == OFS_GPR) || (PADDR == OFS_STAT) ||
    (PADDR == OFS_CTL0) || (PADDR == OFS_CTL1) || (PADDR == OFS_MODE);
  wire busy = (state != ST_IDLE);
  wire cmd_wr = apb_wr && (PADDR == OFS_CMD) && !busy;
  wire [4:0] cmd_op = PWDATA[OP_LSB +: OP_W];
  wire [7:0] cmd_arg = PWDATA[ARG_LSB +: 8];
  wire cmd_byte = PWDATA[BYTE_BIT];
  wire cmd_sel = PWDATA[SEL_BIT];
  wire cmd_free = (cmd_op == OP_NOP) || (cmd_op == OP_FLAG_TOGGLE) ||
    (cmd_op == OP_FLAG_HIGH) || (cmd_op == OP_FLAG_CLEAR) ||
    (cmd_op == OP_FB_STORE) || (cmd_op == OP_FB_LOAD);
  wire cmd_ok = cmd_free || sys_mode;
  wire cmd_block = (cmd_op >= OP_BRD_DN) && (cmd_op <= OP_SBWR_DN);
  wire [7:0] flag_byte = {flags[ST_C], flags[ST_Z], flags[ST_S], flags[ST_PV], 4'h0};

  // Status word
  wire [31:0] stat_word = {20'h0, ~MULTICPU_OUT_LINE_N, halted, priv_err, busy, 2'b00,
    ien, flags};
  assign PRDATA = (PADDR == OFS_SRC) ? {16'h0, src} :
    (PADDR == OFS_DST) ? {16'h0, dst} :
    (PADDR == OFS_CNT) ? {16'h0, cnt} :
    (PADDR == OFS_GPR) ? {16'h0, gpr} :
    (PADDR == OFS_STAT) ? stat_word :
    (PADDR == OFS_CTL0) ? {16'h0, ctl0} :
    (PADDR == OFS_CTL1) ? {16'h0, ctl1} :
    (PADDR == OFS_MODE) ? {31'h0, sys_mode} :
    (PADDR == OFS_CMD) ? {27'h0, op} : 32'h0;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (!apb_rd_hit || (PWRITE && PADDR == OFS_CMD && busy));

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  // inbound directions write memory
  wire op_in = (op == OP_BRD_DN) || (op == OP_BRD_UP) || (op == OP_SRD_STEP_DN);
  wire op_dn = (op == OP_BRD_DN) || (op == OP_BWR_DN) || (op == OP_SRD_STEP_DN) ||
    (op == OP_SBWR_DN);
  wire op_special = (op == OP_SRD_STEP_DN) || (op == OP_SWR_STEP_UP) || (op == OP_SBWR_DN);
  wire op_single = (op == OP_SRD_STEP_DN) || (op == OP_SWR_STEP_UP);
  wire [15:0] step = is_byte ? 16'h0001 : 16'h0002;
  wire [15:0] next_cnt = cnt - 16'h0001;
  wire [15:0] mem_ptr = op_in ? dst : src;
  wire [15:0] next_ptr = op_dn ? (mem_ptr - step) : (mem_ptr + step);
  wire [15:0] port_ptr = op_in ? src : dst;

  // Port data FIFO in front of memory writes
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire port_rd_take = (state == ST_XFER) && op_in && PORT_ACK;
  cio_fifo #(.WIDTH(16), .DEPTH(16)) cio_fifo_inst (
    .clk(CLK),
    .rstn(RSTN),
    .in_valid(port_rd_take),
    .in_ready(fifo_in_ready),
    .in_data(is_byte ? {8'h00, PORT_RDATA[7:0]} : PORT_RDATA),
    .out_valid(fifo_out_valid),
    .out_ready((state == ST_MEMRD) && op_in && MEM_ACK),
    .out_data(fifo_out_data)
  );

  // Bus outputs
  assign PORT_REQ = (state == ST_XFER) && (op_in ? fifo_in_ready : 1'b1);
  assign PORT_WR = !op_in;
  assign PORT_SPECIAL = op_special;
  assign PORT_BYTE = is_byte;
  assign PORT_ADDR = port_ptr;
  assign PORT_WDATA = hold;
  assign MEM_REQ = (state == ST_MEMRD) && (op_in ? fifo_out_valid : 1'b1);
  assign MEM_WR = op_in;
  assign MEM_BYTE = is_byte;
  assign MEM_ADDR = mem_ptr;
  assign MEM_WDATA = fifo_out_data;
  assign MULTICPU_OUT_LINE_N = !mline;
  assign NONVECTORED_IRQ_EN = ien[0];
  assign VECTORED_IRQ_EN = ien[1];

  // Control state machine
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      op <= OP_NOP;
      is_byte <= 1'b0;
      hold <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_wr && cmd_ok && cmd_block) begin
            op <= cio_op_t'(cmd_op);
            is_byte <= cmd_byte;
            state <= (cmd_op == OP_BRD_DN || cmd_op == OP_BRD_UP ||
              cmd_op == OP_SRD_STEP_DN) ? ST_XFER : ST_MEMRD;
          end else if (cmd_wr) begin
            op <= cio_op_t'(cmd_op);
          end
        end
        // Write path: memory read first; read path: memory write last
        ST_MEMRD: begin
          if (MEM_REQ && MEM_ACK) begin
            hold <= is_byte ? {8'h00, MEM_RDATA[7:0]} : MEM_RDATA;
            state <= op_in ? ST_STEP : ST_XFER;
          end
        end
        ST_XFER: begin
          if (PORT_REQ && PORT_ACK) state <= op_in ? ST_MEMRD : ST_STEP;
        end
        ST_STEP: begin
          if (op_single || next_cnt == 16'h0000) state <= ST_IDLE;
          else state <= op_in ? ST_XFER : ST_MEMRD;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Address and count registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      src <= 16'h0000;
      dst <= 16'h0000;
      cnt <= 16'h0000;
    end else if (state == ST_STEP) begin
      if (op_in) dst <= next_ptr;
      else src <= next_ptr;
      cnt <= next_cnt;
    end else if (apb_wr && !busy) begin
      if (PADDR == OFS_SRC) src <= PWDATA[15:0];
      if (PADDR == OFS_DST) dst <= PWDATA[15:0];
      if (PADDR == OFS_CNT) cnt <= PWDATA[15:0];
    end
  end

  // ************************************************************
  // Control operations
  // ************************************************************
  wire do_ctl = cmd_wr && cmd_ok;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags <= FLAGS_RST;
      ien <= IEN_RST;
      sys_mode <= SYS_RST;
      mline <= 1'b0;
      halted <= 1'b0;
      priv_err <= 1'b0;
      gpr <= 16'h0000;
      ctl0 <= 16'h0000;
      ctl1 <= 16'h0000;
    end else begin
      if (cmd_wr && !cmd_ok) priv_err <= 1'b1;
      else if (apb_wr && PADDR == OFS_STAT && PWDATA[ST_PRIV]) priv_err <= 1'b0;
      if (apb_wr && !busy && PADDR == OFS_GPR) gpr <= PWDATA[15:0];
      if (apb_wr && !busy && PADDR == OFS_MODE) sys_mode <= PWDATA[0];
      if (do_ctl) begin
        case (cmd_op)
          OP_IRQ_UNMASK: ien <= ien | cmd_arg[1:0];
          OP_IRQ_MASK: ien <= ien & ~cmd_arg[1:0];
          OP_FLAG_TOGGLE: flags <= flags ^ cmd_arg[3:0];
          OP_FLAG_HIGH: flags <= flags | cmd_arg[3:0];
          OP_FLAG_CLEAR: flags <= flags & ~cmd_arg[3:0];
          OP_CTL_STORE: begin
            if (cmd_sel) ctl1 <= gpr;
            else ctl0 <= gpr;
          end
          OP_CTL_LOAD: gpr <= cmd_sel ? ctl1 : ctl0;
          OP_FB_STORE: flags <= {gpr[4], gpr[5], gpr[6], gpr[7]};
          OP_FB_LOAD: gpr <= {gpr[15:8], flag_byte};
          OP_MLINE_TEST: flags[ST_S] <= MULTICPU_IN_LINE_N;
          OP_MLINE_ASSERT: mline <= 1'b1;
          OP_MLINE_RELEASE: mline <= 1'b0;
          OP_HALT: halted <= 1'b1;
          OP_LOAD_PS: begin
            flags <= {gpr[4], gpr[5], gpr[6], gpr[7]};
            sys_mode <= gpr[14];
          end
          default: halted <= halted;
        endcase
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // privileged op refused in user mode
  a_priv_refused: assert property (@(posedge CLK) disable iff (!RSTN)
    cmd_wr && !sys_mode && cmd_op == OP_IRQ_UNMASK |=> $stable(ien) && priv_err)
    else $error("privileged op ran in user mode");
  a_irq_unmask: assert property (@(posedge CLK) disable iff (!RSTN)
    do_ctl && cmd_op == OP_IRQ_UNMASK |=> ien == ($past(ien) | $past(cmd_arg[1:0])))
    else $error("unmask wrong");
  a_flag_toggle: assert property (@(posedge CLK) disable iff (!RSTN)
    do_ctl && cmd_op == OP_FLAG_TOGGLE |=> flags == ($past(flags) ^ $past(cmd_arg[3:0])))
    else $error("toggle wrong");
  a_line_test: assert property (@(posedge CLK) disable iff (!RSTN)
    do_ctl && cmd_op == OP_MLINE_TEST |=> flags[ST_S] == $past(MULTICPU_IN_LINE_N))
    else $error("line test wrong");
  a_line_drive: assert property (@(posedge CLK) disable iff (!RSTN)
    do_ctl && cmd_op == OP_MLINE_ASSERT |=> !MULTICPU_OUT_LINE_N)
    else $error("line not low");
  a_step_size: assert property (@(posedge CLK) disable iff (!RSTN)
    state == ST_STEP && !op_in && !op_dn |=> src == $past(src) + (is_byte ? 16'h1 : 16'h2))
    else $error("step wrong");
  a_count_dec: assert property (@(posedge CLK) disable iff (!RSTN)
    state == ST_STEP |=> cnt == $past(cnt) - 16'h1)
    else $error("count not decremented");
  a_single_end: assert property (@(posedge CLK) disable iff (!RSTN)
    state == ST_STEP && op_single |=> state == ST_IDLE)
    else $error("single step repeated");
  a_ctl_load: assert property (@(posedge CLK) disable iff (!RSTN)
    do_ctl && cmd_op == OP_CTL_LOAD && !cmd_sel |=> gpr == $past(ctl0))
    else $error("control load wrong");
endmodule // cio_top

/* File: tb/cio_periph_model.sv */
// Purpose: peripheral port and memory partner for the I/O unit
// Assumes: one request open at a time, answer is a one-cycle ack
// Notes: answers alternate prompt and three cycles late
`timescale 1ns/10ps
module cio_periph_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Port side
  input wire logic port_req,
  input wire logic port_wr,
  input wire logic port_special,
  input wire logic port_byte,
  input wire logic [15:0] port_addr,
  input wire logic [15:0] port_wdata,
  output logic port_ack,
  output logic [15:0] port_rdata,
  // Memory side
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [1:0] lag;
  logic slow;
  int rd_n, pwr_n, mwr_n, sp_n;
  logic [15:0] last_p, last_m, last_pa, last_ma;
  logic last_pb, last_mb;
  wire pend = (port_req & ~port_ack) | (mem_req & ~mem_ack);
  // Ack after a varying delay; idle data lines flip every cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {port_ack, mem_ack, slow, lag, port_rdata, mem_rdata, last_p, last_m} <= '0;
      {last_pa, last_ma, last_pb, last_mb} <= '0;
      {rd_n, pwr_n, mwr_n, sp_n} <= '0;
    end else begin
      port_ack <= 1'b0;
      mem_ack <= 1'b0;
      port_rdata <= ~port_rdata;
      mem_rdata <= ~mem_rdata;
      if (pend && lag != (slow ? 2'd3 : 2'd0)) begin
        lag <= lag + 2'd1;
      end else if (pend && port_req) begin
        lag <= 2'd0;
        slow <= ~slow;
        port_ack <= 1'b1;
        sp_n <= sp_n + int'(port_special);
        last_pa <= port_addr;
        last_pb <= port_byte;
        if (port_wr) begin
          pwr_n <= pwr_n + 1;
          last_p <= port_wdata;
        end else begin
          rd_n <= rd_n + 1;
          port_rdata <= 16'h3C00 + 16'(rd_n);
        end
      end else if (pend) begin
        lag <= 2'd0;
        slow <= ~slow;
        mem_ack <= 1'b1;
        mem_rdata <= mem_addr ^ 16'hA5A5;
        last_ma <= mem_addr;
        last_mb <= mem_byte;
        if (mem_wr) begin
          mwr_n <= mwr_n + 1;
          last_m <= mem_wdata;
        end
      end
    end
  end
endmodule // cio_periph_model

/* File: tb/cio_top_bench.sv */
// Purpose: self-checking bench for the I/O and control unit
// Assumes: APB slave, partner model on port and memory
// Notes: transfers run from a table of cases
`timescale 1ns/10ps
module cio_top_bench;
  import cio_pkg::*;
  typedef struct {logic [4:0] op; logic b; int n;} cio_case_t;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MULTICPU_IN_LINE_N = 1;
  logic [7:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic PREADY, PSLVERR, PORT_REQ, PORT_WR, PORT_SPECIAL, PORT_BYTE, PORT_ACK, err;
  logic MEM_REQ, MEM_WR, MEM_BYTE, MEM_ACK, MULTICPU_OUT_LINE_N;
  logic NONVECTORED_IRQ_EN, VECTORED_IRQ_EN;
  logic [15:0] PORT_ADDR, PORT_WDATA, PORT_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [15:0] ea, lst, fin, msk;
  logic rdop, up, one;
  int fail_count = 0, total_checks = 0, cyc = 0, stp, np, rd0, pw0, mw0, sp0;
  cio_case_t tc[7] = '{'{OP_BRD_DN, 1'b0, 3}, '{OP_BRD_UP, 1'b1, 4}, '{OP_BWR_DN, 1'b1, 3},
    '{OP_BWR_UP, 1'b0, 3}, '{OP_SRD_STEP_DN, 1'b0, 3}, '{OP_SWR_STEP_UP, 1'b1, 2},
    '{OP_SBWR_DN, 1'b0, 3}};

  cio_top cio_top_inst (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PORT_REQ(PORT_REQ), .PORT_WR(PORT_WR), .PORT_SPECIAL(PORT_SPECIAL),
    .PORT_BYTE(PORT_BYTE), .PORT_ADDR(PORT_ADDR), .PORT_WDATA(PORT_WDATA),
    .PORT_ACK(PORT_ACK), .PORT_RDATA(PORT_RDATA), .MEM_REQ(MEM_REQ), .MEM_WR(MEM_WR),
    .MEM_BYTE(MEM_BYTE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .MULTICPU_IN_LINE_N(MULTICPU_IN_LINE_N),
    .MULTICPU_OUT_LINE_N(MULTICPU_OUT_LINE_N), .NONVECTORED_IRQ_EN(NONVECTORED_IRQ_EN),
    .VECTORED_IRQ_EN(VECTORED_IRQ_EN));
  cio_periph_model cio_periph_model_inst (.clk(CLK), .rstn(RSTN), .port_req(PORT_REQ),
    .port_wr(PORT_WR), .port_special(PORT_SPECIAL), .port_byte(PORT_BYTE),
    .port_addr(PORT_ADDR), .port_wdata(PORT_WDATA),
    .port_ack(PORT_ACK), .port_rdata(PORT_RDATA), .mem_req(MEM_REQ), .mem_wr(MEM_WR),
    .mem_byte(MEM_BYTE),
    .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));

  // Clock and hang guard
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  // One APB transfer; answer taken at the edge where ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic idle();
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, OFS_STAT, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    chk(rd[ST_BUSY], 1'b0);
  endtask
  task automatic go(input logic [4:0] op, input logic [7:0] arg, input logic s = 1'b0);
    apb(1'b1, OFS_CMD, {14'h0, s, 1'b0, arg, 3'h0, op});
    idle();
  endtask
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    st(32'hF3F, 32'h0);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd[0], 1'b1);
    chk({MULTICPU_OUT_LINE_N, NONVECTORED_IRQ_EN, VECTORED_IRQ_EN}, 3'b100);
    apb(1'b0, 8'hFC, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    go(OP_IRQ_UNMASK, 8'h01);
    chk({NONVECTORED_IRQ_EN, VECTORED_IRQ_EN}, 2'b10);
    go(OP_IRQ_UNMASK, 8'h02);
    chk({NONVECTORED_IRQ_EN, VECTORED_IRQ_EN}, 2'b11);
    go(OP_IRQ_MASK, 8'h01);
    st(32'h30, 32'h20);
    go(OP_FLAG_HIGH, 8'h05);
    go(OP_FLAG_TOGGLE, 8'h03);
    st(32'hF, 32'h6);
    go(OP_FLAG_CLEAR, 8'h04);
    st(32'hF, 32'h2);
    apb(1'b1, OFS_GPR, 32'h1234);
    go(OP_CTL_STORE, 8'h00, 1'b1);
    apb(1'b0, OFS_CTL1, 32'h0);
    chk(rd, 32'h1234);
    apb(1'b1, OFS_GPR, 32'hBEEF);
    go(OP_CTL_STORE, 8'h00, 1'b0);
    apb(1'b1, OFS_GPR, 32'h0);
    go(OP_CTL_LOAD, 8'h00, 1'b1);
    apb(1'b0, OFS_GPR, 32'h0);
    chk(rd, 32'h1234);
    go(OP_CTL_LOAD, 8'h00, 1'b0);
    apb(1'b0, OFS_GPR, 32'h0);
    chk(rd, 32'hBEEF);
    go(OP_MLINE_TEST, 8'h00);
    st(32'h4, 32'h4);
    MULTICPU_IN_LINE_N <= 1'b0;
    go(OP_MLINE_TEST, 8'h00);
    st(32'h4, 32'h0);
    go(OP_MLINE_ASSERT, 8'h00);
    chk(MULTICPU_OUT_LINE_N, 1'b0);
    go(OP_MLINE_RELEASE, 8'h00);
    chk(MULTICPU_OUT_LINE_N, 1'b1);
    apb(1'b1, OFS_GPR, 32'hA0);
    go(OP_FB_STORE, 8'h00);
    st(32'hF, 32'h5);
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_GPR, 32'h0);
    go(OP_FB_LOAD, 8'h00);
    apb(1'b0, OFS_GPR, 32'h0);
    chk(rd & 32'hF0, 32'hA0);
    go(OP_IRQ_UNMASK, 8'h03);
    go(OP_MLINE_ASSERT, 8'h00);
    chk({NONVECTORED_IRQ_EN, VECTORED_IRQ_EN, MULTICPU_OUT_LINE_N}, 3'b011);
    go(OP_FLAG_TOGGLE, 8'h01);
    st(32'h20F, 32'h204);
    apb(1'b1, OFS_STAT, 32'h200);
    st(32'h200, 32'h0);
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_GPR, 32'h0050);
    go(OP_LOAD_PS, 8'h00);
    st(32'hF, 32'hA);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h0);
    go(OP_HALT, 8'h00);
    st(32'h600, 32'h200);
    apb(1'b1, OFS_STAT, 32'h200);
    apb(1'b1, OFS_MODE, 32'h1);
    go(OP_HALT, 8'h00);
    st(32'h600, 32'h400);
    foreach (tc[k]) begin
      rd0 = cio_periph_model_inst.rd_n;
      pw0 = cio_periph_model_inst.pwr_n;
      mw0 = cio_periph_model_inst.mwr_n;
      sp0 = cio_periph_model_inst.sp_n;
      rdop = tc[k].op inside {OP_BRD_DN, OP_BRD_UP, OP_SRD_STEP_DN};
      up = tc[k].op inside {OP_BRD_UP, OP_BWR_UP, OP_SWR_STEP_UP};
      one = tc[k].op inside {OP_SRD_STEP_DN, OP_SWR_STEP_UP};
      stp = tc[k].b ? 1 : 2;
      np = one ? 1 : tc[k].n;
      msk = tc[k].b ? 16'h00FF : 16'hFFFF;
      ea = rdop ? 16'h0400 : 16'h0200;
      lst = up ? ea + 16'(stp * (np - 1)) : ea - 16'(stp * (np - 1));
      fin = up ? ea + 16'(stp * np) : ea - 16'(stp * np);
      apb(1'b1, OFS_SRC, 32'h0200);
      apb(1'b1, OFS_DST, 32'h0400);
      apb(1'b1, OFS_CNT, 32'(tc[k].n));
      apb(1'b1, OFS_CMD, {15'h0, tc[k].b, 11'h0, tc[k].op});
      apb(1'b1, OFS_CMD, 32'h0);
      chk(err, 1'b1);
      idle();
      apb(1'b0, rdop ? OFS_DST : OFS_SRC, 32'h0);
      chk(rd, {16'h0, fin});
      apb(1'b0, OFS_CNT, 32'h0);
      chk(rd, 32'(tc[k].n - np));
      if (rdop) begin
        chk(32'(cio_periph_model_inst.mwr_n - mw0), 32'(np));
        chk(cio_periph_model_inst.last_m & msk, (16'h3C00 + 16'(rd0 + np - 1)) & msk);
      end else begin
        chk(32'(cio_periph_model_inst.pwr_n - pw0), 32'(np));
        chk(cio_periph_model_inst.last_p & msk, (lst ^ 16'hA5A5) & msk);
      end
      chk(32'(cio_periph_model_inst.sp_n - sp0), (tc[k].op > 5'h04) ? 32'(np) : 32'h0);
      chk(cio_periph_model_inst.last_ma, lst);
      chk(cio_periph_model_inst.last_pa, rdop ? 32'h0200 : 32'h0400);
      chk({cio_periph_model_inst.last_pb, cio_periph_model_inst.last_mb}, {2{tc[k].b}});
    end
    end_sim();
  end
endmodule // cio_top_bench
